// file: sws_ctl_model.sv
// Purpose: controller model on the command and data pins
// Assumes: write latency of five clocks
// Notes: the bench calls its tasks
`timescale 1ns/1ps
`default_nettype none
module sws_ctl_model (
    input wire logic aclk,
    output var sws_pkg::sws_pins_t pins,
    output logic [15:0] dq_pair,
    output logic [1:0] dm_pair
);
    localparam int WR_GAP = 4;
    logic dqs_t = 1'b0;
    logic dqs_oe = 1'b0;
    initial begin
        pins = 25'h1b8_0000;
        dq_pair = 16'h0000;
        dm_pair = 2'b00;
    end
    task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a,
                       input logic ke);
        @(posedge aclk);
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= c;
        pins.ba <= b;
        pins.addr <= a;
        pins.cke <= ke;
        pins.odt <= 1'b0;
        @(posedge aclk);
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h7;
        pins.addr <= ~a;
    endtask : cmd
    task automatic wr(input logic [2:0] b, input logic a12, input int n, input logic [1:0] m,
                      input int slot);
        cmd(4'h4, b, {2'b00, a12, 12'h000}, 1'b1);
        repeat (3) @(posedge aclk);
        dqs_oe <= 1'b1;
        dqs_t <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < n; i++) begin
            dq_pair <= {4'h1, 4'(i), 4'h2, 4'(i)};
            dm_pair <= (i == 0) ? m : 2'b00;
            dqs_t <= ~dqs_t;
            @(posedge aclk);
        end
        dq_pair <= ~dq_pair;
        dm_pair <= 2'b00;
        dqs_t <= 1'b0;
        @(posedge aclk);
        dqs_oe <= 1'b0;
        repeat (slot - n) @(posedge aclk);
        repeat (WR_GAP) @(posedge aclk);
    endtask : wr
endmodule : sws_ctl_model
`default_nettype wire

// file: sws_ddr3_dev.sv
// Purpose: DDR3-class device core: burst type, banks, precharge, self refresh
// Assumes: command pins sampled once per aclk, two write beats per aclk
// Notes: registers over AXI4-Lite
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - write is eight beats for field 00, or field 01 with A12 high
// - field 01 with A12 low chops that read or write to four beats
// - field 10 chops every read and write to four beats
// - precharge with A10 high closes all banks, else the addressed one
// - precharged bank is idle and must be activated before access
// - refresh with CKE low enters self refresh, held while CKE low
// - DLL off in self refresh, re-enabled and reset on exit
// - self refresh ignores all but CKE and reset, refreshes once early
// - exit timers start at first edge with CKE seen high
// - first write beat follows the write by additive plus write latency
// - masked beats are discarded, unmasked beats stored
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module sws_ddr3_dev #(
    parameter int XS_CYC = sws_pkg::XS_CYC,
    parameter int XSDLL_CYC = sws_pkg::XSDLL_CYC,
    parameter int DEPTH = sws_pkg::WL_DEPTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire sws_pkg::sws_pins_t pins,
    input wire logic [2*sws_pkg::DQ_W-1:0] dq_pair,
    input wire logic [1:0] dm_pair,
    output logic dll_locked
);

    localparam int CW = sws_pkg::CNT_W;
    localparam int DW = sws_pkg::DQ_W;
    localparam logic [CW-1:0] XS_LOAD = CW'(XS_CYC - 1);
    localparam logic [CW-1:0] DLL_LOAD = CW'(XSDLL_CYC - 1);

    if (XS_CYC < 1 || XS_CYC > 1024 || XSDLL_CYC < 1 || XSDLL_CYC > 1024) begin : g_chk
        $error("sws_ddr3_dev: exit counts must lie in 1..1024");
    end

    typedef struct packed {
        sws_pkg::sws_pins_t p1;
        sws_pkg::sws_pins_t p2;
        logic [2*DW-1:0] d1;
        logic [2*DW-1:0] d2;
        logic [1:0] m1;
        logic [1:0] m2;
        logic cke_q;
        sws_pkg::sws_sr_t sr;
        logic [sws_pkg::BANKS-1:0] bank_open;
        logic [CW-1:0] tcnt;
        logic [CW-1:0] dll_cnt;
        logic dll_on;
        logic dll_locked;
        logic last_chop;
        logic int_ref;
        logic [31:0] cfg;
        logic [sws_pkg::ERR_W-1:0] err;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sws_dev_t;

    sws_dev_t st;
    sws_dev_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // command decode
    logic cmd_ok;
    logic cmd_act;
    logic cmd_rd;
    logic cmd_wr;
    logic cmd_pre;
    logic cmd_sre;
    logic cmd_any;
    logic chop;
    logic [1:0] bl_mode;
    logic wr_start;
    logic [15:0] stored_cnt;
    logic [15:0] masked_cnt;
    logic [DW-1:0] last_data;
    logic [4:0] wl;

    assign cmd_ok = st.cke_q && !st.p2.cs_n;
    assign cmd_act = cmd_ok && st.p2.cke && !st.p2.ras_n && st.p2.cas_n && st.p2.we_n;
    assign cmd_rd = cmd_ok && st.p2.cke && st.p2.ras_n && !st.p2.cas_n && st.p2.we_n;
    assign cmd_wr = cmd_ok && st.p2.cke && st.p2.ras_n && !st.p2.cas_n && !st.p2.we_n;
    assign cmd_pre = cmd_ok && st.p2.cke && !st.p2.ras_n && st.p2.cas_n && !st.p2.we_n;
    assign cmd_sre = cmd_ok && !st.p2.cke && !st.p2.ras_n && !st.p2.cas_n && st.p2.we_n;
    assign cmd_any = cmd_ok && !(st.p2.ras_n && st.p2.cas_n && st.p2.we_n);
    assign bl_mode = st.cfg[sws_pkg::CFG_BL_LSB +: 2];
    assign chop = (bl_mode == sws_pkg::BL_FIXED4)
        || (bl_mode == sws_pkg::BL_OTF && !st.p2.addr[sws_pkg::A12_BIT]);
    assign wl = 5'(st.cfg[sws_pkg::CFG_AL_LSB +: 4]) + 5'(st.cfg[sws_pkg::CFG_CWL_LSB +: 4]);
    assign wr_start = (st.sr == sws_pkg::SR_NORM) && cmd_wr && st.bank_open[st.p2.ba];

    sws_wr_burst #(
        .DW(DW),
        .DEPTH(DEPTH)
    ) u_wr (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(wr_start),
        .chop(chop),
        .wl(wl),
        .dq_pair(st.d2),
        .dm_pair(st.m2),
        .stored_cnt(stored_cnt),
        .masked_cnt(masked_cnt),
        .last_data(last_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_st = st;
        next_st.p1 = pins;
        next_st.p2 = st.p1;
        next_st.d1 = dq_pair;
        next_st.d2 = st.d1;
        next_st.m1 = dm_pair;
        next_st.m2 = st.m1;
        next_st.cke_q = st.p2.cke;
        next_st.int_ref = 1'b0;

        // register writes, clears before hardware sets
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (st.aw_got && st.w_got && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = sws_pkg::RESP_OKAY;
            unique case ({st.awaddr[7:2], 2'h0})
                sws_pkg::OFF_CFG: begin
                    for (int i = 0; i < 4; i++) begin
                        if (st.wstrb[i]) begin
                            next_st.cfg[8*i +: 8] = st.wdata[8*i +: 8];
                        end
                    end
                end
                sws_pkg::OFF_ERR: begin
                    if (st.wstrb[0]) begin
                        next_st.err = st.err & ~st.wdata[sws_pkg::ERR_W-1:0];
                    end
                end
                sws_pkg::OFF_STATUS, sws_pkg::OFF_COUNT, sws_pkg::OFF_LAST: begin
                end
                default: begin
                    next_st.bresp = sws_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready = !next_st.w_got && !next_st.bvalid;

        // register reads
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = sws_pkg::RESP_OKAY;
            next_st.rdata = 32'h0000_0000;
            unique case ({s_axi_araddr[7:2], 2'h0})
                sws_pkg::OFF_CFG: next_st.rdata = st.cfg;
                sws_pkg::OFF_STATUS: begin
                    next_st.rdata[sws_pkg::ST_BANK_LSB +: sws_pkg::BANKS] = st.bank_open;
                    next_st.rdata[sws_pkg::ST_SR_LSB +: 2] = st.sr;
                    next_st.rdata[sws_pkg::ST_DLL_BIT] = st.dll_locked;
                    next_st.rdata[sws_pkg::ST_CHOP_BIT] = st.last_chop;
                end
                sws_pkg::OFF_COUNT: next_st.rdata = {masked_cnt, stored_cnt};
                sws_pkg::OFF_ERR: next_st.rdata[sws_pkg::ERR_W-1:0] = st.err;
                sws_pkg::OFF_LAST: next_st.rdata[DW-1:0] = last_data;
                default: next_st.rresp = sws_pkg::RESP_SLVERR;
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        next_st.arready = !next_st.rvalid;

        // dll lock countdown after re-enable
        if (st.dll_on && !st.dll_locked) begin
            if (st.dll_cnt == '0) begin
                next_st.dll_locked = 1'b1;
            end else begin
                next_st.dll_cnt = st.dll_cnt - CW'(1);
            end
        end

        // command handling
        unique case (st.sr)
            sws_pkg::SR_NORM: begin
                if (cmd_act) begin
                    next_st.bank_open[st.p2.ba] = 1'b1;
                end
                if ((cmd_rd || cmd_wr) && !st.bank_open[st.p2.ba]) begin
                    next_st.err[sws_pkg::ERR_IDLE_BIT] = 1'b1;
                end
                if ((cmd_rd || cmd_wr) && st.bank_open[st.p2.ba]) begin
                    next_st.last_chop = chop;
                end
                if (cmd_pre) begin
                    if (st.p2.addr[sws_pkg::A10_BIT]) begin
                        next_st.bank_open = '0;
                    end else begin
                        next_st.bank_open[st.p2.ba] = 1'b0;
                    end
                end
                if (cmd_sre) begin
                    next_st.sr = sws_pkg::SR_IN;
                    next_st.dll_on = 1'b0;
                    next_st.dll_locked = 1'b0;
                    next_st.int_ref = 1'b1;
                    if (st.bank_open != '0) begin
                        next_st.err[sws_pkg::ERR_OPEN_BIT] = 1'b1;
                    end
                    if (st.p2.odt && (st.cfg[sws_pkg::CFG_NOM_BIT] || st.cfg[sws_pkg::CFG_DYN_BIT])) begin
                        next_st.err[sws_pkg::ERR_ODT_BIT] = 1'b1;
                    end
                end
            end
            sws_pkg::SR_IN: begin
                if (st.p2.cke) begin
                    next_st.sr = sws_pkg::SR_EXIT;
                    next_st.tcnt = XS_LOAD;
                    next_st.dll_on = 1'b1;
                    next_st.dll_cnt = DLL_LOAD;
                end
            end
            sws_pkg::SR_EXIT: begin
                if (cmd_any) begin
                    next_st.err[sws_pkg::ERR_EXIT_BIT] = 1'b1;
                end
                if (st.tcnt == '0) begin
                    next_st.sr = sws_pkg::SR_NORM;
                end else begin
                    next_st.tcnt = st.tcnt - CW'(1);
                end
            end
            default: begin
                next_st.sr = sws_pkg::SR_NORM;
            end
        endcase

        // device reset pin
        if (!st.p2.rst_n) begin
            next_st.bank_open = '0;
            next_st.sr = sws_pkg::SR_NORM;
            next_st.dll_on = 1'b1;
            next_st.dll_locked = 1'b0;
            next_st.dll_cnt = DLL_LOAD;
        end

        if (!aresetn) begin
            next_st = '0;
            next_st.cfg = sws_pkg::CFG_RST;
            next_st.sr = sws_pkg::SR_NORM;
            next_st.dll_on = 1'b1;
            next_st.dll_cnt = DLL_LOAD;
        end
    end

    always_ff @(posedge aclk) begin
        st <= next_st;
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign dll_locked = st.dll_locked;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !st.p2.rst_n);

    sequence s_sre;
        (st.sr == sws_pkg::SR_NORM) && cmd_sre;
    endsequence

    sequence s_exit;
        (st.sr == sws_pkg::SR_IN) && st.p2.cke;
    endsequence

    AST_PRE_ALL: assert property (
        ((st.sr == sws_pkg::SR_NORM) && cmd_pre && st.p2.addr[sws_pkg::A10_BIT])
        |=> (st.bank_open == '0)
    ) else $error("precharge all left a bank open");

    AST_PRE_ONE: assert property (
        ((st.sr == sws_pkg::SR_NORM) && cmd_pre && !st.p2.addr[sws_pkg::A10_BIT])
        |=> (!st.bank_open[$past(st.p2.ba)]
            && ((st.bank_open | (8'h01 << $past(st.p2.ba))) == ($past(st.bank_open) | (8'h01 << $past(st.p2.ba)))))
    ) else $error("single bank precharge hit wrong bank");

    AST_IDLE_ACCESS: assert property (
        ((st.sr == sws_pkg::SR_NORM) && (cmd_rd || cmd_wr) && !st.bank_open[st.p2.ba])
        |-> !wr_start ##1 st.err[sws_pkg::ERR_IDLE_BIT]
    ) else $error("access to idle bank not flagged");

    AST_SRE_ENTRY: assert property (
        s_sre |=> (st.sr == sws_pkg::SR_IN) && !st.dll_on && !st.dll_locked && st.int_ref
    ) else $error("self refresh entry incomplete");

    AST_SR_HOLD: assert property (
        ((st.sr == sws_pkg::SR_IN) && !st.p2.cke) |=> (st.sr == sws_pkg::SR_IN)
    ) else $error("left self refresh with CKE low");

    AST_SR_IGNORE: assert property (
        (st.sr == sws_pkg::SR_IN) |=> $stable(st.bank_open) && !st.int_ref
    ) else $error("command acted in self refresh");

    AST_EXIT_TIMER: assert property (
        s_exit |=> (st.sr == sws_pkg::SR_EXIT) && (st.tcnt == XS_LOAD)
            && (st.dll_cnt == DLL_LOAD) && st.dll_on && !st.dll_locked
    ) else $error("exit timers not started at CKE high");

    AST_BL8: assert property (
        ((st.sr == sws_pkg::SR_NORM) && cmd_wr && st.bank_open[st.p2.ba]
            && (bl_mode == sws_pkg::BL_FIXED8
                || (bl_mode == sws_pkg::BL_OTF && st.p2.addr[sws_pkg::A12_BIT])))
        |=> !st.last_chop
    ) else $error("eight beat write marked as chop");

    AST_BC4: assert property (
        ((st.sr == sws_pkg::SR_NORM) && (cmd_rd || cmd_wr) && st.bank_open[st.p2.ba]
            && (bl_mode == sws_pkg::BL_FIXED4
                || (bl_mode == sws_pkg::BL_OTF && !st.p2.addr[sws_pkg::A12_BIT])))
        |=> st.last_chop
    ) else $error("chopped access not marked as chop");

endmodule : sws_ddr3_dev
`default_nettype wire

// file: sws_ddr3_dev_tb.sv
// Purpose: self-checking bench of the device core
// Assumes: controller model drives the pins
// Notes: short DLL lock count
`timescale 1ns/1ps
`default_nettype none
module sws_ddr3_dev_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, dll_locked;
    logic [1:0] bresp, rresp, dm_pair, r;
    logic [31:0] rdata, d;
    logic [15:0] dq_pair;
    sws_pkg::sws_pins_t pins;
    int bad_count = 0;
    int n_compared = 0;
    int i;
    always #10 aclk = ~aclk;
    sws_ddr3_dev #(.XSDLL_CYC(8)) sws_ddr3_dev_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .pins(pins), .dq_pair(dq_pair),
        .dm_pair(dm_pair), .dll_locked(dll_locked));
    sws_ctl_model sws_ctl_model_i (.aclk(aclk), .pins(pins), .dq_pair(dq_pair),
        .dm_pair(dm_pair));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    task automatic tmo;
        if (i >= 50) begin
            bad_count++;
            stop_test();
        end
    endtask : tmo
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        tmo();
        chk("bresp", {30'h0, bresp}, 32'h0000_0000);
    endtask : axw
    task automatic axr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        tmo();
        d = rdata;
        r = rresp;
    endtask : axr
    ////////////////////////////////////////////////////////////////////////////
    task automatic s_regs;
        axr(sws_pkg::OFF_CFG);
        chk("cfg", d, sws_pkg::CFG_RST);
        axr(8'h14);
        chk("unmapped", {r, d[29:0]}, {sws_pkg::RESP_SLVERR, 30'h0});
    endtask : s_regs
    task automatic s_burst;
        logic [1:0] bl [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
        logic a12 [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        int st = 0;
        int mk = 0;
        for (int k = 0; k < 4; k++) begin
            int n;
            n = (k < 2) ? 4 : 2;
            axw(sws_pkg::OFF_CFG, {30'h0000_0140, bl[k]});
            sws_ctl_model_i.cmd(4'h3, 3'h3, 15'h0000, 1'b1);
            sws_ctl_model_i.wr(3'h3, a12[k], n, (k == 1) ? 2'b11 : 2'b10, (k == 3) ? 2 : 4);
            mk += (k == 1) ? 2 : 1;
            st += 2 * n - ((k == 1) ? 2 : 1);
            repeat (4) @(posedge aclk);
            axr(sws_pkg::OFF_STATUS);
            chk("chop", {31'h0, d[sws_pkg::ST_CHOP_BIT]}, {31'h0, n == 2});
            axr(sws_pkg::OFF_COUNT);
            chk("count", d, {16'(mk), 16'(st)});
            axr(sws_pkg::OFF_LAST);
            chk("last", d, {24'h0, 4'h1, 4'(n - 1)});
        end
    endtask : s_burst
    task automatic s_prech;
        sws_ctl_model_i.cmd(4'h3, 3'h1, 15'h0000, 1'b1);
        sws_ctl_model_i.cmd(4'h3, 3'h5, 15'h0000, 1'b1);
        sws_ctl_model_i.cmd(4'h2, 3'h1, 15'h0000, 1'b1);
        repeat (4) @(posedge aclk);
        axr(sws_pkg::OFF_STATUS);
        chk("banks", {24'h0, d[7:0]}, 32'h0000_0028);
        sws_ctl_model_i.cmd(4'h2, 3'h1, 15'h0400, 1'b1);
        sws_ctl_model_i.wr(3'h5, 1'b1, 4, 2'b00, 4);
        repeat (4) @(posedge aclk);
        axr(sws_pkg::OFF_STATUS);
        chk("banks", {24'h0, d[7:0]}, 32'h0000_0000);
        axr(sws_pkg::OFF_ERR);
        chk("err", d, 32'h0000_0001);
        axw(sws_pkg::OFF_ERR, 32'h0000_000f);
        axr(sws_pkg::OFF_ERR);
        chk("err", d, 32'h0000_0000);
    endtask : s_prech
    task automatic s_sref;
        sws_ctl_model_i.cmd(4'h1, 3'h0, 15'h0000, 1'b0);
        sws_ctl_model_i.cmd(4'h3, 3'h2, 15'h0000, 1'b0);
        repeat (10) @(posedge aclk);
        axr(sws_pkg::OFF_STATUS);
        chk("sr", {21'h0, d[10:0]}, 32'h0000_0100);
        sws_ctl_model_i.cmd(4'h7, 3'h0, 15'h0000, 1'b1);
        repeat (20) @(posedge aclk);
        axr(sws_pkg::OFF_STATUS);
        chk("sr", {21'h0, d[10:0]}, 32'h0000_0400);
        chk("dll", {31'h0, dll_locked}, 32'h0000_0001);
        axr(sws_pkg::OFF_ERR);
        chk("err", d, 32'h0000_0000);
    endtask : s_sref
    task automatic s_srerr;
        axw(sws_pkg::OFF_CFG, 32'h0000_1501);
        sws_ctl_model_i.cmd(4'h3, 3'h2, 15'h0000, 1'b1);
        sws_ctl_model_i.cmd(4'h5, 3'h2, 15'h1000, 1'b1);
        sws_ctl_model_i.cmd(4'h1, 3'h0, 15'h0000, 1'b0);
        repeat (4) @(posedge aclk);
        sws_ctl_model_i.cmd(4'h7, 3'h0, 15'h0000, 1'b1);
        sws_ctl_model_i.cmd(4'h2, 3'h0, 15'h0400, 1'b1);
        repeat (20) @(posedge aclk);
        axr(sws_pkg::OFF_STATUS);
        chk("status", {20'h0, d[11:0]}, 32'h0000_0404);
        axr(sws_pkg::OFF_ERR);
        chk("err", d, 32'h0000_000a);
    endtask : s_srerr
    task automatic s_reset;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(sws_pkg::OFF_CFG);
        chk("cfg", d, sws_pkg::CFG_RST);
        axr(sws_pkg::OFF_STATUS);
        chk("status", {22'h0, d[9:0]}, 32'h0000_0000);
        axr(sws_pkg::OFF_COUNT);
        chk("count", d, 32'h0000_0000);
        axr(sws_pkg::OFF_ERR);
        chk("err", d, 32'h0000_0000);
    endtask : s_reset
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        s_regs();
        s_burst();
        s_prech();
        s_sref();
        s_srerr();
        s_reset();
        stop_test();
    end
endmodule : sws_ddr3_dev_tb
`default_nettype wire

// file: sws_pkg.sv
// Purpose: shared constants and types of the write, precharge and self refresh core
// Assumes: 32-bit AXI4-Lite register bus, 8-bit byte addresses
// Notes: one number, one name
package sws_pkg;

    localparam int DQ_W = 8;
    localparam int BANKS = 8;
    localparam int ADDR_W = 15;
    localparam int CNT_W = 10;
    localparam int WL_DEPTH = 32;

    // register byte offsets
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_COUNT = 8'h08;
    localparam logic [7:0] OFF_ERR = 8'h0C;
    localparam logic [7:0] OFF_LAST = 8'h10;

    // configuration fields
    localparam int CFG_BL_LSB = 0;
    localparam int CFG_AL_LSB = 4;
    localparam int CFG_CWL_LSB = 8;
    localparam int CFG_NOM_BIT = 12;
    localparam int CFG_DYN_BIT = 13;
    localparam logic [31:0] CFG_RST = 32'h0000_0500;

    // status fields
    localparam int ST_BANK_LSB = 0;
    localparam int ST_SR_LSB = 8;
    localparam int ST_DLL_BIT = 10;
    localparam int ST_CHOP_BIT = 11;

    // sticky error bits, write one to clear
    localparam int ERR_IDLE_BIT = 0;
    localparam int ERR_EXIT_BIT = 1;
    localparam int ERR_ODT_BIT = 2;
    localparam int ERR_OPEN_BIT = 3;
    localparam int ERR_W = 4;

    // burst length field codes
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;

    localparam int A10_BIT = 10;
    localparam int A12_BIT = 12;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_XS_NS = 170;
    localparam int XS_CYC = (T_XS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XSDLL_CYC = 512;

    typedef enum logic [1:0] {SR_NORM, SR_IN, SR_EXIT} sws_sr_t;

    typedef struct packed {
        logic rst_n;
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic odt;
        logic [2:0] ba;
        logic [ADDR_W-1:0] addr;
    } sws_pins_t;

endpackage : sws_pkg

// file: sws_wr_burst.sv
// Purpose: write data capture after the write latency, with data mask
// Assumes: data and start arrive with equal pipeline delay, two beats per clock
// Notes: overlapping writes queue in a start pipeline
`timescale 1ns/1ps
`default_nettype none
module sws_wr_burst #(
    parameter int DW = sws_pkg::DQ_W,
    parameter int DEPTH = sws_pkg::WL_DEPTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic chop,
    input wire logic [4:0] wl,
    input wire logic [2*DW-1:0] dq_pair,
    input wire logic [1:0] dm_pair,
    output logic [15:0] stored_cnt,
    output logic [15:0] masked_cnt,
    output logic [DW-1:0] last_data
);

    if (DEPTH < 32 || DW < 1) begin : g_chk
        $error("sws_wr_burst: DEPTH must cover the largest write latency");
    end

    typedef struct packed {
        logic [DEPTH-1:0] pipe;
        logic [DEPTH-1:0] chop_pipe;
        logic [1:0] left;
        logic [15:0] stored;
        logic [15:0] masked;
        logic [DW-1:0] last;
    } sws_wb_t;

    sws_wb_t st;
    sws_wb_t next_st;
    logic tap;
    logic tap_chop;
    logic active;

    always_comb begin
        next_st = st;
        next_st.pipe = {st.pipe[DEPTH-2:0], start};
        next_st.chop_pipe = {st.chop_pipe[DEPTH-2:0], chop};
        tap = (wl != 5'h00) && st.pipe[wl - 5'h01];
        tap_chop = (wl != 5'h00) && st.chop_pipe[wl - 5'h01];
        active = tap || (st.left != 2'h0);
        if (tap) begin
            next_st.left = tap_chop ? 2'h1 : 2'h3;
        end else if (st.left != 2'h0) begin
            next_st.left = st.left - 2'h1;
        end
        if (active) begin
            for (int i = 0; i < 2; i++) begin
                if (!dm_pair[i]) begin
                    next_st.stored = next_st.stored + 16'h0001;
                    next_st.last = dq_pair[i*DW +: DW];
                end else begin
                    next_st.masked = next_st.masked + 16'h0001;
                end
            end
        end
        if (!aresetn) begin
            next_st = '0;
        end
    end

    always_ff @(posedge aclk) begin
        st <= next_st;
    end

    assign stored_cnt = st.stored;
    assign masked_cnt = st.masked;
    assign last_data = st.last;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_MASKED_KEPT: assert property (
        (active && dm_pair == 2'h3) |=> ($stable(st.stored) && st.masked == $past(st.masked) + 16'h0002)
    ) else $error("masked beats changed stored count");

    AST_BC4_SLOT: assert property (
        (tap && tap_chop && !st.pipe[wl - 5'h02]) |=> (st.left == 2'h1) ##1 (st.left == 2'h0)
    ) else $error("four beat chop did not last two clocks");

endmodule : sws_wr_burst
`default_nettype wire
